// ---- logic/pmi_pkg.sv ----
// Purpose: shared constants and carrier types for the microphone receiver
// Assumes: one 20 MHz clock; samples leave through a word-wide memory write port
// Notes:   gain codes step half a decibel; code 40 is unity gain
package pmi_pkg;
    localparam int          CLK_HZ          = 20_000_000; // system clock rate
    localparam int          SAMPLE_W        = 16;         // pcm sample width
    localparam int          OUT_RATE_HZ     = 16_000;     // nominal output rate
    localparam logic [6:0]  RATIO_LOW       = 7'h40;      // 64 bit clocks per sample
    localparam logic [6:0]  RATIO_HIGH      = 7'h50;      // 80 bit clocks per sample
    localparam int          PCM_SHIFT       = 8;          // ones-count to pcm scaling
    localparam logic [6:0]  GAIN_LOWEST     = 7'h00;      // lowest_gain_code, -20 dB
    localparam logic [6:0]  GAIN_HIGHEST    = 7'h50;      // highest_gain_code, +20 dB
    localparam logic [6:0]  GAIN_DEFAULT    = 7'h28;      // reset gain, unity
    localparam logic [6:0]  GAIN_BIAS       = 7'h08;      // lifts codes onto a 12-step grid
    localparam logic [6:0]  STEPS_PER_OCT   = 7'h0c;      // half-dB steps per doubling
    localparam int          GAIN_FRAC_W     = 12;         // fraction bits of gain table
    localparam int          GAIN_UNITY_OCT  = 4;          // octave index of unity gain
    localparam logic [7:0]  DIV_DEFAULT     = 8'h08;      // half period, 1.25 MHz bit clock
    localparam logic [31:0] ADDR_STEP       = 32'h0000_0004; // bytes per ram word
    localparam logic [15:0] PCM_MAX         = 16'h7fff;   // saturation ceiling
    localparam logic [15:0] PCM_MIN         = 16'h8000;   // saturation floor

    // one stereo frame of gained samples
    typedef struct packed {
        logic signed [SAMPLE_W-1:0] right;
        logic signed [SAMPLE_W-1:0] left;
    } pmi_frame_t;

    // one ram word write
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } pmi_mem_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_WRITE
    } pmi_state_t;
endpackage : pmi_pkg

// ---- logic/pmi_top.sv ----
// Purpose: pdm microphone receiver, decimation, gain and sample storage
// Assumes: mic_bit_clock is made here; din is asynchronous and synchronised
// Notes:   bit clock is divided from REF_CLK only, so it carries that clock's jitter
//
// Functional notes
// - drive bit clock; mono or stereo input
// - at most two microphones share one input
// - sixteen-bit samples, nominally sixteen kilohertz
// - settable divider, no added jitter
// - default: left on falling, right rising
// - swap exchanges capture edges
// - each channel decimated to sixteen-bit pcm
// - ratio sixty-four or eighty bit clocks
// - one buffer; stereo alternates, mono left
// - start runs; stop after current frame
// - halted event once writes finished
// - volume spans twenty decibels either way
// - left and right gains independent
// - gain code half decibel per count
// - address double-buffered, reload after started
// - buffer full: end, switch, started again
// - length in samples; left low half
`timescale 1ns/1ps
module pmi_top
    import pmi_pkg::*;
#(
    parameter int LEN_W = 15 // sample_buffer_length width
) (
    input  wire logic             REF_CLK,
    input  wire logic             RST,
    input  wire logic             START,
    input  wire logic             STOP,
    input  wire logic             MIC_DIN,
    input  wire logic [7:0]       BIT_CLOCK_FREQUENCY_SELECT,
    input  wire logic             EDGE_SWAP,
    input  wire logic             STEREO,
    input  wire logic             RATIO_80,
    input  wire logic [6:0]       LEFT_GAIN_SETTING,
    input  wire logic [6:0]       RIGHT_GAIN_SETTING,
    input  wire logic [31:0]      SAMPLE_BUFFER_ADDRESS,
    input  wire logic [LEN_W-1:0] SAMPLE_BUFFER_LENGTH,
    input  wire logic             MEM_ACK,
    output logic                  MIC_BIT_CLOCK,
    output logic                  MEM_REQ,
    output pmi_mem_t              MEM_WR,
    output logic                  EV_STARTED,
    output logic                  EV_END,
    output logic                  EV_STOPPED,
    output logic                  BUSY
);
    // ---------------- bit clock divider ----------------
    logic [7:0] div_cnt, next_div_cnt;   // cycles in current half period
    logic       bclk, next_bclk;         // bit clock level
    logic       rise_p, next_rise_p;     // bit clock just rose
    logic       fall_p, next_fall_p;     // bit clock just fell
    logic [7:0] half_per;                // half period, never zero
    pmi_state_t state, next_state;       // acquisition state

    // fixed divide from the clock, idle low while stopped
    always_comb begin
        half_per     = (BIT_CLOCK_FREQUENCY_SELECT == 8'h00) ? 8'h01 : BIT_CLOCK_FREQUENCY_SELECT;
        next_div_cnt = div_cnt + 8'h01;
        next_bclk    = bclk;
        next_rise_p  = 1'b0;
        next_fall_p  = 1'b0;
        if (state == ST_IDLE) begin
            next_div_cnt = 8'h00;
            next_bclk    = 1'b0;
        end else if (div_cnt >= half_per - 8'h01) begin
            next_div_cnt = 8'h00;
            next_bclk    = ~bclk;
            next_rise_p  = ~bclk;
            next_fall_p  = bclk;
        end
    end

    // divider registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            div_cnt <= 8'h00;
            bclk    <= 1'b0;
            rise_p  <= 1'b0;
            fall_p  <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            bclk    <= next_bclk;
            rise_p  <= next_rise_p;
            fall_p  <= next_fall_p;
        end
    end
    assign MIC_BIT_CLOCK = bclk;

    // ---------------- capture and decimation ----------------
    logic       din_s1, din_s2;          // data synchroniser
    logic [6:0] ones_l, next_ones_l;     // left ones in this frame
    logic [6:0] ones_r, next_ones_r;     // right ones in this frame
    logic [6:0] bit_cnt, next_bit_cnt;   // bit clock periods in frame
    logic [6:0] cap_l, next_cap_l;       // finished left count
    logic [6:0] cap_r, next_cap_r;       // finished right count
    logic       frame_p, next_frame_p;   // counts just finished
    logic [6:0] ratio;                   // periods per output sample
    logic       take_l, take_r;          // capture strobes per channel

    // shared pin: left and right pick opposite edges
    always_comb begin
        ratio        = RATIO_80 ? RATIO_HIGH : RATIO_LOW;
        take_l       = EDGE_SWAP ? rise_p : fall_p;
        take_r       = EDGE_SWAP ? fall_p : rise_p;
        next_ones_l  = ones_l + {6'h00, take_l & din_s2};
        next_ones_r  = ones_r + {6'h00, take_r & din_s2};
        next_bit_cnt = bit_cnt;
        next_cap_l   = cap_l;
        next_cap_r   = cap_r;
        next_frame_p = 1'b0;
        if (state == ST_IDLE) begin
            next_ones_l  = 7'h00;
            next_ones_r  = 7'h00;
            next_bit_cnt = 7'h00;
        end else if (fall_p) begin
            // a period ends on the falling edge (rise came first)
            if (bit_cnt == ratio - 7'h01) begin
                next_cap_l   = next_ones_l;
                next_cap_r   = next_ones_r;
                next_frame_p = 1'b1;
                next_ones_l  = 7'h00;
                next_ones_r  = 7'h00;
                next_bit_cnt = 7'h00;
            end else begin
                next_bit_cnt = bit_cnt + 7'h01;
            end
        end
    end

    // capture registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
            ones_l  <= 7'h00;
            ones_r  <= 7'h00;
            bit_cnt <= 7'h00;
            cap_l   <= 7'h00;
            cap_r   <= 7'h00;
            frame_p <= 1'b0;
        end else begin
            din_s1  <= MIC_DIN;
            din_s2  <= din_s1;
            ones_l  <= next_ones_l;
            ones_r  <= next_ones_r;
            bit_cnt <= next_bit_cnt;
            cap_l   <= next_cap_l;
            cap_r   <= next_cap_r;
            frame_p <= next_frame_p;
        end
    end

    // ---------------- volume stage ----------------
    // 2^(k/12) in 12 fraction bits: one half-dB step apart
    function automatic logic [12:0] frac_gain(input logic [6:0] k);
        unique case (k)
            7'h00:   frac_gain = 13'h1000;
            7'h01:   frac_gain = 13'h10f4;
            7'h02:   frac_gain = 13'h11f6;
            7'h03:   frac_gain = 13'h1307;
            7'h04:   frac_gain = 13'h1429;
            7'h05:   frac_gain = 13'h155c;
            7'h06:   frac_gain = 13'h16a1;
            7'h07:   frac_gain = 13'h17f9;
            7'h08:   frac_gain = 13'h1966;
            7'h09:   frac_gain = 13'h1ae9;
            7'h0a:   frac_gain = 13'h1c82;
            default: frac_gain = 13'h1e34;
        endcase
    endfunction : frac_gain

    // pcm from ones count, gain, then clamp to 16 bits
    function automatic logic [15:0] apply_gain(input logic [6:0] ones, input logic [6:0] ratio_v,
                                               input logic [6:0] code);
        logic signed [8:0]  diff;
        logic signed [15:0] pcm;
        logic [6:0]         grid;
        logic [6:0]         oct;
        logic signed [39:0] prod;
        logic signed [39:0] scaled;
        diff   = $signed({1'b0, ones, 1'b0}) - $signed({2'b00, ratio_v});
        pcm    = 16'(diff <<< PCM_SHIFT);
        grid   = code + GAIN_BIAS;
        oct    = grid / STEPS_PER_OCT;
        prod   = 40'(pcm) * $signed({27'h0, frac_gain(7'(grid % STEPS_PER_OCT))});
        scaled = (prod <<< oct) >>> (GAIN_FRAC_W + GAIN_UNITY_OCT);
        if (scaled > 40'(signed'(PCM_MAX)))
            apply_gain = PCM_MAX;
        else if (scaled < 40'(signed'(PCM_MIN)))
            apply_gain = PCM_MIN;
        else
            apply_gain = scaled[15:0];
    endfunction : apply_gain

    pmi_frame_t frame, next_frame;       // gained stereo sample pair
    logic       frame_v, next_frame_v;   // pair just produced

    // independent gain per channel
    always_comb begin
        next_frame   = frame;
        next_frame_v = frame_p;
        if (frame_p) begin
            next_frame.left  = apply_gain(cap_l, ratio, LEFT_GAIN_SETTING);
            next_frame.right = apply_gain(cap_r, ratio, RIGHT_GAIN_SETTING);
        end
    end

    // volume registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            frame   <= '0;
            frame_v <= 1'b0;
        end else begin
            frame   <= next_frame;
            frame_v <= next_frame_v;
        end
    end

    // ---------------- storage and control ----------------
    logic [31:0]      wr_addr, next_wr_addr;   // next ram word address
    logic [LEN_W-1:0] buf_len, next_buf_len;   // active buffer length
    logic [LEN_W:0]   cnt, next_cnt;           // samples placed in buffer
    logic             stop_pend, next_stop_pend; // stop waiting for frame end
    logic             half, next_half;         // mono word half filled
    logic [15:0]      half_l, next_half_l;     // first mono sample of word
    logic             next_req;                // write request
    pmi_mem_t         next_wr;                 // write contents
    logic             next_ev_started;
    logic             next_ev_end;
    logic             next_ev_stopped;
    logic             done;                    // write completes the buffer

    always_comb begin
        next_state      = state;
        next_wr_addr    = wr_addr;
        next_buf_len    = buf_len;
        next_cnt        = cnt;
        next_stop_pend  = stop_pend | (STOP & (state != ST_IDLE));
        next_half       = half;
        next_half_l     = half_l;
        next_req        = MEM_REQ;
        next_wr         = MEM_WR;
        next_ev_started = 1'b0;
        next_ev_end     = 1'b0;
        next_ev_stopped = 1'b0;
        done            = cnt >= {1'b0, buf_len};
        unique case (state)
            ST_IDLE: begin
                if (START) begin
                    next_state      = ST_RUN;
                    next_wr_addr    = SAMPLE_BUFFER_ADDRESS;
                    next_buf_len    = SAMPLE_BUFFER_LENGTH;
                    next_cnt        = '0;
                    next_half       = 1'b0;
                    next_ev_started = 1'b1;
                end
            end
            ST_RUN: begin
                if (frame_v) begin
                    next_wr.addr = wr_addr;
                    if (STEREO) begin
                        next_wr.data = {frame.right, frame.left};
                        next_cnt     = cnt + 2'd2;
                        next_req     = 1'b1;
                        next_state   = ST_WRITE;
                    end else if (half) begin
                        next_wr.data = {frame.left, half_l};
                        next_cnt     = cnt + 1'b1;
                        next_half    = 1'b0;
                        next_req     = 1'b1;
                        next_state   = ST_WRITE;
                    end else begin
                        next_half_l  = frame.left;
                        next_half    = 1'b1;
                        next_cnt     = cnt + 1'b1;
                        // odd length or stop: flush the lone low half
                        if (cnt + 1'b1 >= {1'b0, buf_len} || next_stop_pend) begin
                            next_wr.data = {16'h0000, frame.left};
                            next_half    = 1'b0;
                            next_req     = 1'b1;
                            next_state   = ST_WRITE;
                        end
                    end
                end
            end
            ST_WRITE: begin
                if (MEM_ACK) begin
                    next_req     = 1'b0;
                    next_wr_addr = wr_addr + ADDR_STEP;
                    next_state   = ST_RUN;
                    if (done || next_stop_pend) begin
                        next_ev_end = 1'b1;
                    end
                    if (next_stop_pend) begin
                        next_state      = ST_IDLE;
                        next_stop_pend  = 1'b0;
                        next_ev_stopped = 1'b1;
                    end else if (done) begin
                        next_wr_addr    = SAMPLE_BUFFER_ADDRESS;
                        next_buf_len    = SAMPLE_BUFFER_LENGTH;
                        next_cnt        = '0;
                        next_ev_started = 1'b1;
                    end
                end
            end
        endcase
    end

    // storage registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state      <= ST_IDLE;
            wr_addr    <= 32'h0000_0000;
            buf_len    <= '0;
            cnt        <= '0;
            stop_pend  <= 1'b0;
            half       <= 1'b0;
            half_l     <= 16'h0000;
            MEM_REQ    <= 1'b0;
            MEM_WR     <= '0;
            EV_STARTED <= 1'b0;
            EV_END     <= 1'b0;
            EV_STOPPED <= 1'b0;
            BUSY       <= 1'b0;
        end else begin
            state      <= next_state;
            wr_addr    <= next_wr_addr;
            buf_len    <= next_buf_len;
            cnt        <= next_cnt;
            stop_pend  <= next_stop_pend;
            half       <= next_half;
            half_l     <= next_half_l;
            MEM_REQ    <= next_req;
            MEM_WR     <= next_wr;
            EV_STARTED <= next_ev_started;
            EV_END     <= next_ev_end;
            EV_STOPPED <= next_ev_stopped;
            BUSY       <= next_state != ST_IDLE;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    property p_clk_idle;
        (state == ST_IDLE) |=> !MIC_BIT_CLOCK;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("bit clock not low while idle");

    property p_half_period;
        $rose(MIC_BIT_CLOCK) && $stable(BIT_CLOCK_FREQUENCY_SELECT) && state != ST_IDLE
            && BIT_CLOCK_FREQUENCY_SELECT == DIV_DEFAULT |-> (MIC_BIT_CLOCK || !BUSY) [*8];
    endproperty
    a_half_period: assert property (p_half_period) else $error("bit clock half period wrong");

    property p_left_edge;
        fall_p && !EDGE_SWAP && state != ST_IDLE && !frame_p && !next_frame_p
            && next_state != ST_IDLE |=> ones_l == $past(ones_l) + 7'($past(din_s2));
    endproperty
    a_left_edge: assert property (p_left_edge) else $error("left bit not taken on fall");

    property p_swap_edge;
        rise_p && EDGE_SWAP && state != ST_IDLE && next_state != ST_IDLE
            |=> ones_r == $past(ones_r);
    endproperty
    a_swap_edge: assert property (p_swap_edge) else $error("right taken on rise in swap");

    property p_ratio;
        frame_p |-> cap_l <= ratio && cap_r <= ratio;
    endproperty
    a_ratio: assert property (p_ratio) else $error("ones count exceeds ratio");

    property p_unity;
        frame_p && LEFT_GAIN_SETTING == GAIN_DEFAULT && cap_l == ratio
            |=> frame.left == 16'({ratio, 8'h00});
    endproperty
    a_unity: assert property (p_unity) else $error("unity gain altered sample");

    property p_restart;
        EV_END && !EV_STOPPED |-> EV_STARTED;
    endproperty
    a_restart: assert property (p_restart) else $error("buffer switch lacks started");

    property p_stopped;
        EV_STOPPED |-> EV_END && !BUSY && !MEM_REQ && $past(MEM_ACK);
    endproperty
    a_stopped: assert property (p_stopped) else $error("halted before write done");

    property p_stereo_word;
        MEM_REQ && !$past(MEM_REQ) && STEREO && $past(STEREO)
            |-> MEM_WR.data == {$past(frame.right), $past(frame.left)};
    endproperty
    a_stereo_word: assert property (p_stereo_word) else $error("stereo word packed wrong");
endmodule : pmi_top

// ---- verification/pmi_mic_model.sv ----
// Purpose: behavioural pair of pdm microphones sharing one data line
// Assumes: left mic drives while the bit clock is high, right mic while it is low
// Notes:   with no right mic fitted the low phase shows the inverse level, never a held value
`timescale 1ns/1ps
module pmi_mic_model (
    input  wire logic mic_bit_clock, // bit clock from the receiver
    input  wire logic left_bit,      // left mic constant density
    input  wire logic right_bit,     // right mic constant density
    input  wire logic right_present, // second mic fitted
    output logic      mic_din        // shared data line
);
    // each mic owns one phase of the shared line
    always_comb begin
        if (mic_bit_clock)
            mic_din = left_bit;
        else if (right_present)
            mic_din = right_bit;
        else
            mic_din = ~left_bit; // released line
    end
endmodule : pmi_mic_model

// ---- verification/pmi_top_tb_top.sv ----
// Purpose: self-checking bench for the pdm microphone receiver
// Assumes: constant-density mics, so every full frame decimates to a known value
// Notes:   first word's data is skipped in each run as the filter may still settle
`timescale 1ns/1ps
module pmi_top_tb_top;
    import pmi_pkg::*;
    logic       REF_CLK, RST, START, STOP, MIC_DIN, EDGE_SWAP, STEREO, RATIO_80, MEM_ACK;
    logic       MIC_BIT_CLOCK, MEM_REQ, EV_STARTED, EV_END, EV_STOPPED, BUSY;
    logic [7:0] BIT_CLOCK_FREQUENCY_SELECT;
    logic [6:0] LEFT_GAIN_SETTING, RIGHT_GAIN_SETTING;
    logic [31:0] SAMPLE_BUFFER_ADDRESS;
    logic [14:0] SAMPLE_BUFFER_LENGTH;
    pmi_mem_t   MEM_WR;
    pmi_mem_t   wq[$];                         // writes taken by the memory
    logic       left_bit, right_bit, right_present, bclk_q, req_q, end_start, stop_end, stopped;
    int         n_errors, n_checks, cyc, bclk_t, bclk_per, req_t, req_per, n_end, ack_dly, wcnt;

    pmi_top #(.LEN_W(15)) u_dut (.REF_CLK(REF_CLK), .RST(RST), .START(START), .STOP(STOP),
        .MIC_DIN(MIC_DIN), .BIT_CLOCK_FREQUENCY_SELECT(BIT_CLOCK_FREQUENCY_SELECT),
        .EDGE_SWAP(EDGE_SWAP), .STEREO(STEREO), .RATIO_80(RATIO_80),
        .LEFT_GAIN_SETTING(LEFT_GAIN_SETTING), .RIGHT_GAIN_SETTING(RIGHT_GAIN_SETTING),
        .SAMPLE_BUFFER_ADDRESS(SAMPLE_BUFFER_ADDRESS),
        .SAMPLE_BUFFER_LENGTH(SAMPLE_BUFFER_LENGTH), .MEM_ACK(MEM_ACK),
        .MIC_BIT_CLOCK(MIC_BIT_CLOCK), .MEM_REQ(MEM_REQ), .MEM_WR(MEM_WR),
        .EV_STARTED(EV_STARTED), .EV_END(EV_END), .EV_STOPPED(EV_STOPPED), .BUSY(BUSY));
    pmi_mic_model u_mics (.mic_bit_clock(MIC_BIT_CLOCK), .left_bit(left_bit),
        .right_bit(right_bit), .right_present(right_present), .mic_din(MIC_DIN));

    // steady crystal-like clock source, 50 ns period
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end

    // memory side: accepts a write after ack_dly cycles, stalling when asked
    always @(negedge REF_CLK) begin
        if (MEM_ACK)
            MEM_ACK <= 1'b0;
        else if (MEM_REQ && wcnt >= ack_dly) begin
            MEM_ACK <= 1'b1;
            wq.push_back(MEM_WR);
            wcnt = 0;
        end else if (MEM_REQ)
            wcnt++;
    end

    // monitor: bit clock period, write spacing and event coincidences
    always @(negedge REF_CLK) begin
        cyc++;
        if (MIC_BIT_CLOCK && !bclk_q) begin
            bclk_per = cyc - bclk_t;
            bclk_t = cyc;
        end
        if (MEM_REQ && !req_q) begin
            req_per = cyc - req_t;
            req_t = cyc;
        end
        bclk_q = MIC_BIT_CLOCK;
        req_q = MEM_REQ;
        if (EV_END) begin
            n_end++;
            end_start = EV_STARTED;
        end
        if (EV_STOPPED) begin
            stopped = 1'b1;
            stop_end = EV_END;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // waits a bounded time for the next accepted write
    task automatic wait_word(output pmi_mem_t w);
        for (int n = 0; n < 4000 && wq.size() == 0; n++)
            @(negedge REF_CLK);
        check(wq.size() != 0, 1'b1);
        w = (wq.size() != 0) ? wq.pop_front() : '0;
    endtask : wait_word

    // loads buffer settings and sends the start task
    task automatic do_start(input logic [31:0] addr, input logic [14:0] len);
        SAMPLE_BUFFER_ADDRESS = addr;
        SAMPLE_BUFFER_LENGTH = len;
        n_end = 0;
        @(negedge REF_CLK);
        START = 1'b1;
        @(negedge REF_CLK);
        START = 1'b0;
        check(EV_STARTED, 1'b1);
        check(BUSY, 1'b1);
    endtask : do_start

    // stop, then hold off any restart until the halted event
    task automatic do_stop;
        stopped = 1'b0;
        @(negedge REF_CLK);
        STOP = 1'b1;
        @(negedge REF_CLK);
        STOP = 1'b0;
        for (int n = 0; n < 6000 && !stopped; n++)
            @(negedge REF_CLK);
        check(stop_end, 1'b1);
        check(BUSY, 1'b0);
        wq.delete();
    endtask : do_stop

    // stereo at unity gain, buffer switch after four samples
    task automatic t_stereo;
        pmi_mem_t w;
        do_start(32'h0000_0100, 15'h0004);
        SAMPLE_BUFFER_ADDRESS = 32'h0000_0200;
        wait_word(w);
        check(w.addr, 32'h0000_0100);
        wait_word(w);
        check(w.addr, 32'h0000_0104);
        check(w.data, 32'hc000_4000);
        wait_word(w);
        check(w.addr, 32'h0000_0200);
        check(n_end, 1);
        check(end_start, 1'b1);
        check(req_per, 1024);
        check(bclk_per, 16);
        do_stop;
    endtask : t_stereo

    // swapped edges, +6 dB saturating on one side and -6 dB on the other
    task automatic t_swap_gain;
        pmi_mem_t w;
        EDGE_SWAP = 1'b1;
        LEFT_GAIN_SETTING = 7'h1c;
        RIGHT_GAIN_SETTING = 7'h34;
        do_start(32'h0000_0400, 15'h7fff);
        wait_word(w);
        wait_word(w);
        check(w.data[15:0], 32'h0000_e000);
        check(w.data[31:16], 32'h0000_7fff);
        do_stop;
    endtask : t_swap_gain

    // mono, ratio 80, faster bit clock, quarter gain, stalled memory
    task automatic t_mono80;
        pmi_mem_t w;
        EDGE_SWAP = 1'b0;
        STEREO = 1'b0;
        RATIO_80 = 1'b1;
        right_present = 1'b0;
        ack_dly = 20;
        BIT_CLOCK_FREQUENCY_SELECT = 8'h04;
        LEFT_GAIN_SETTING = 7'h10;
        do_start(32'h0000_0300, 15'h0064);
        wait_word(w);
        wait_word(w);
        check(w.addr, 32'h0000_0304);
        check(w.data, 32'h1400_1400);
        check(req_per, 1280);
        check(bclk_per, 8);
        do_stop;
    endtask : t_mono80

    // main sequence
    initial begin
        {RST, START, STOP, EDGE_SWAP, RATIO_80, MEM_ACK, bclk_q, req_q, stopped} = '0;
        RST = 1'b1;
        STEREO = 1'b1;
        {left_bit, right_bit, right_present} = 3'b101;
        BIT_CLOCK_FREQUENCY_SELECT = 8'h08;
        LEFT_GAIN_SETTING = 7'h28;
        RIGHT_GAIN_SETTING = 7'h28;
        SAMPLE_BUFFER_ADDRESS = '0;
        SAMPLE_BUFFER_LENGTH = '0;
        {n_errors, n_checks, cyc, bclk_t, bclk_per, req_t, req_per, n_end, ack_dly, wcnt} = '0;
        repeat (6) @(negedge REF_CLK);
        RST = 1'b0;
        check(MIC_BIT_CLOCK, 1'b0);
        t_stereo;
        t_swap_gain;
        t_mono80;
        end_of_test;
    end

    // watchdog, well beyond the few thousand cycles per scenario
    initial begin
        #3_000_000;
        n_errors++;
        end_of_test;
    end
endmodule : pmi_top_tb_top
